// >>> verilog/lbd_pkg.sv
/*
 * Shared constants and carrier types of the LED bypass PWM fade dimmer.
 * Assumes a 200 MHz core clock and a register port fed by a serial
 * front end outside this design.
 */
package lbd_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_SW    = 12;   // Bypass switches
	localparam int CNT_W     = 12;   // PWM counter width
	localparam int DUTY_W    = 13;   // Duty holds 0..4096
	localparam int HOLD_W    = 8;    // Step-hold register width
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 16;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_GO_CTRL  = 8'h01; // Output go control
	localparam logic [7:0] OFS_GEN_CFG  = 8'h02; // General configuration
	localparam logic [7:0] OFS_FADE_SEL = 8'h03; // Per-switch fade select
	localparam logic [7:0] OFS_ID_CODE  = 8'h04; // ID and binning codes
	localparam logic [7:0] OFS_THERM    = 8'h05; // Thermistor result
	localparam logic [7:0] OFS_DUTY     = 8'h20; // Duty target, +switch
	localparam logic [7:0] OFS_PHASE    = 8'h40; // Phase delay, +switch
	localparam logic [7:0] OFS_HOLD     = 8'h60; // Step hold, +switch

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int GO_EN_BIT   = 0;  // output_go_enable
	localparam int CLK_SEL_LSB = 0;  // Clock select [1:0]
	localparam int DIV_LSB     = 2;  // Dimming divider [3:2]
	localparam logic [7:0]  RST_GO_CTRL = 8'h00;
	localparam logic [7:0]  RST_GEN_CFG = 8'h00;
	localparam logic [DUTY_W-1:0] RST_DUTY = 13'h0000;
	localparam logic [HOLD_W-1:0] RST_HOLD = 8'h01;

	// Clock select codes
	typedef enum logic [1:0] {
		LBD_CLK_INT     = 2'h0,  // Internal, in and out off
		LBD_CLK_INT_OUT = 2'h1,  // Internal, forwarded out
		LBD_CLK_EXT     = 2'h2,  // External in, out off
		LBD_CLK_EXT_OUT = 2'h3   // External in, passed through
	} lbd_clk_sel_e;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint CORE_HZ   = 200000000;
	localparam longint OSC_HZ    = 16384000;  // Internal oscillator
	localparam int     ACC_W     = 24;        // Oscillator phase accum
	localparam logic [ACC_W-1:0] OSC_INC =
		ACC_W'((OSC_HZ << ACC_W) / CORE_HZ);
	localparam int     THERM_PERIOD_US  = 200;
	localparam int     THERM_PERIOD_CYC =
		int'((longint'(THERM_PERIOD_US) * CORE_HZ) / 1000000);
	localparam int     EXT_LOSS_CYC  = 1024;  // No edge -> clock absent
	localparam int     SPREAD_HOLD_CYC = 256; // Quiet time after access

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DUTY_W-1:0] duty_target;
		logic [CNT_W-1:0]  phase_delay;
		logic [HOLD_W-1:0] step_hold_cycles;
		logic              fade;
	} lbd_chan_cfg_s;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} lbd_reg_req_s;

endpackage : lbd_pkg

// >>> verilog/lbd_channel.sv
/*
 * One bypass switch: phase/duty comparison and fade stepping.
 * Assumes count and its strobes come from the shared timebase.
 */
`timescale 1ns/1ps
module lbd_channel (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	// Configuration and timebase
	input  wire lbd_pkg::lbd_chan_cfg_s    cfg,
	input  wire logic [lbd_pkg::CNT_W-1:0] count,
	input  wire logic                      cnt_adv,
	input  wire logic                      cycle_end,
	input  wire logic                      go_en,
	// Results
	output logic                           switch_open,
	output logic [lbd_pkg::DUTY_W-1:0]     duty_now
);

	logic                         lit;       // Window open
	logic                         next_lit;
	logic                         next_switch_open;
	logic [lbd_pkg::DUTY_W-1:0]   next_duty_now;
	logic [lbd_pkg::HOLD_W-1:0]   hold_cnt;  // Cycles spent on a step
	logic [lbd_pkg::HOLD_W-1:0]   next_hold_cnt;
	logic [lbd_pkg::DUTY_W:0]     win_end;   // Phase plus duty
	logic [lbd_pkg::DUTY_W-1:0]   step;
	logic [lbd_pkg::DUTY_W:0]     cand;
	logic [lbd_pkg::HOLD_W-1:0]   hold_lim;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		win_end = {2'h0, cfg.phase_delay} + {1'h0, duty_now};
		next_lit = lit;
		// Open at phase, close once counter passes phase plus duty
		if (cnt_adv) begin
			if (count == cfg.phase_delay) begin
				next_lit = 1'b1;
			end else if ({2'h0, count} > win_end) begin
				next_lit = 1'b0;
			end
		end
		// Held conducting until go is set
		next_switch_open = go_en & next_lit;

		// Exponential step, at least one code so small duties move
		step = duty_now >> 4;
		if (step == 13'h0000) begin
			step = 13'h0001;
		end
		hold_lim = (cfg.step_hold_cycles == 8'h00) ? 8'h01
			: cfg.step_hold_cycles;
		cand = {1'h0, duty_now};
		next_duty_now = duty_now;
		next_hold_cnt = hold_cnt;
		if (cycle_end) begin
			if (!cfg.fade) begin
				next_duty_now = cfg.duty_target;
				next_hold_cnt = 8'h00;
			end else if (duty_now != cfg.duty_target) begin
				if (hold_cnt + 8'h01 >= hold_lim) begin
					next_hold_cnt = 8'h00;
					if (cfg.duty_target > duty_now) begin
						// Times 1.0625, truncated
						cand = {1'h0, duty_now} + {1'h0, step};
						next_duty_now = (cand >= {1'h0, cfg.duty_target})
							? cfg.duty_target : cand[12:0];
					end else begin
						// Times 0.9375, rounded up
						cand = {1'h0, duty_now} - {1'h0, step};
						next_duty_now = (duty_now <= step
							|| cand <= {1'h0, cfg.duty_target})
							? cfg.duty_target : cand[12:0];
					end
				end else begin
					next_hold_cnt = hold_cnt + 8'h01;
				end
			end else begin
				next_hold_cnt = 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			lit         <= 1'b0;
			switch_open <= 1'b0;
			duty_now    <= lbd_pkg::RST_DUTY;
			hold_cnt    <= 8'h00;
		end else begin
			lit         <= next_lit;
			switch_open <= next_switch_open;
			duty_now    <= next_duty_now;
			hold_cnt    <= next_hold_cnt;
		end
	end

endmodule : lbd_channel

// >>> verilog/lbd_dimmer.sv
/*
 * Top of the LED bypass PWM fade dimmer: registers, PWM timebase,
 * clock selection and forwarding, ID decode, thermistor refresh and
 * twelve switch channels.
 * Assumes a serial front end presents decoded register accesses and
 * an analog front end gives comparator thermometer codes and a
 * converted thermistor code.
 */
// What this block does
// - Power-up: all switches conducting, go cleared
// - Non-conducting lights LEDs, conducting darkens
// - Spreading suspended during serial transactions
// - External clock drives PWM only, pump internal
// - Pin voltages decode to 4-bit codes
// - Switch open from phase until phase+duty exceeded
// - Clock select field picks source and forwarding
// - Missing external clock falls back to internal
// - Divider sets cycle 8192 to 65536 clocks
// - Without fade, new duty within one cycle
// - Fade bit makes writes step toward target
// - Steps multiply by 1.0625 or 0.9375
// - Each step held step-hold dimming cycles
// - Thermistor result refreshed every 200 us
`timescale 1ns/1ps
module lbd_dimmer #(
	parameter int THERM_PERIOD_CYC = lbd_pkg::THERM_PERIOD_CYC,
	parameter bit SPREAD_VARIANT   = 1'b1  // Pump spreading fitted
) (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// Register port from the serial front end
	input  wire lbd_pkg::lbd_reg_req_s       reg_req,
	output logic [lbd_pkg::DATA_W-1:0]       reg_rdata,
	output logic                             reg_rvalid,
	// Pins
	input  wire logic                        ext_timing_input,
	output logic                             timing_forward_output,
	input  wire logic [14:0]                 id_resistor_pin,
	input  wire logic [14:0]                 binning_resistor_pin,
	input  wire logic [7:0]                  thermistor_input,
	// Switch drive, pump timing and pin codes
	output logic [lbd_pkg::NUM_SW-1:0]       switch_open,
	output logic                             pump_tick,
	output logic                             spread_enable,
	output logic [3:0]                       device_id,
	output logic [3:0]                       binning_code
);

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	localparam int N = lbd_pkg::NUM_SW;
	logic [7:0]  go_ctrl, next_go_ctrl;          // Output go control
	logic [7:0]  gen_cfg, next_gen_cfg;          // General configuration
	logic [N-1:0] fade_sel, next_fade_sel;       // Fade select per switch
	logic [lbd_pkg::DUTY_W-1:0] duty_tgt [N];    // Duty targets
	logic [lbd_pkg::DUTY_W-1:0] next_duty_tgt [N];
	logic [lbd_pkg::CNT_W-1:0]  phase [N];       // Phase delays
	logic [lbd_pkg::CNT_W-1:0]  next_phase [N];
	logic [lbd_pkg::HOLD_W-1:0] hold [N];        // Step holds
	logic [lbd_pkg::HOLD_W-1:0] next_hold [N];
	logic [lbd_pkg::DATA_W-1:0] next_rdata;
	logic [7:0]  therm_val, next_therm_val;      // Thermistor result
	logic [lbd_pkg::DUTY_W-1:0] duty_now [N];    // Live duty per switch
	logic [7:0]  idx;                            // Offset within a bank

	// Writes and read mux
	always_comb begin
		next_go_ctrl  = go_ctrl;
		next_gen_cfg  = gen_cfg;
		next_fade_sel = fade_sel;
		next_rdata    = 16'h0000;
		for (int i = 0; i < N; i++) begin
			next_duty_tgt[i] = duty_tgt[i];
			next_phase[i]    = phase[i];
			next_hold[i]     = hold[i];
		end
		idx = reg_req.addr & 8'h1f;
		if (reg_req.wr) begin
			case (reg_req.addr)
				lbd_pkg::OFS_GO_CTRL:  next_go_ctrl = reg_req.wdata[7:0];
				lbd_pkg::OFS_GEN_CFG:  next_gen_cfg = reg_req.wdata[7:0];
				lbd_pkg::OFS_FADE_SEL: next_fade_sel = reg_req.wdata[N-1:0];
				default: begin
					// Banked registers; duty above 4096 saturates
					if (idx < 8'(N)) begin
						case (reg_req.addr & 8'he0)
							lbd_pkg::OFS_DUTY: next_duty_tgt[idx[3:0]] =
								(reg_req.wdata[12:0] > 13'h1000) ? 13'h1000
								: reg_req.wdata[12:0];
							lbd_pkg::OFS_PHASE: next_phase[idx[3:0]] =
								reg_req.wdata[11:0];
							lbd_pkg::OFS_HOLD: next_hold[idx[3:0]] =
								reg_req.wdata[7:0];
							default: ;
						endcase
					end
				end
			endcase
		end
		// Unmapped reads return zero
		case (reg_req.addr)
			lbd_pkg::OFS_GO_CTRL:  next_rdata = {8'h00, go_ctrl};
			lbd_pkg::OFS_GEN_CFG:  next_rdata = {8'h00, gen_cfg};
			lbd_pkg::OFS_FADE_SEL: next_rdata = {4'h0, fade_sel};
			lbd_pkg::OFS_ID_CODE:  next_rdata = {8'h00, binning_code,
				device_id};
			lbd_pkg::OFS_THERM:    next_rdata = {8'h00, therm_val};
			default: begin
				if (idx < 8'(N)) begin
					case (reg_req.addr & 8'he0)
						// Duty reads the live value, showing fade progress
						lbd_pkg::OFS_DUTY:  next_rdata = {3'h0,
							duty_now[idx[3:0]]};
						lbd_pkg::OFS_PHASE: next_rdata = {4'h0,
							phase[idx[3:0]]};
						lbd_pkg::OFS_HOLD:  next_rdata = {8'h00,
							hold[idx[3:0]]};
						default: ;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			go_ctrl    <= lbd_pkg::RST_GO_CTRL;
			gen_cfg    <= lbd_pkg::RST_GEN_CFG;
			fade_sel   <= 12'h000;
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
			for (int i = 0; i < N; i++) begin
				duty_tgt[i] <= lbd_pkg::RST_DUTY;
				phase[i]    <= 12'h000;
				hold[i]     <= lbd_pkg::RST_HOLD;
			end
		end else begin
			go_ctrl    <= next_go_ctrl;
			gen_cfg    <= next_gen_cfg;
			fade_sel   <= next_fade_sel;
			reg_rdata  <= reg_req.rd ? next_rdata : reg_rdata;
			reg_rvalid <= reg_req.rd;
			for (int i = 0; i < N; i++) begin
				duty_tgt[i] <= next_duty_tgt[i];
				phase[i]    <= next_phase[i];
				hold[i]     <= next_hold[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Clock sources
	// ------------------------------------------------------------
	logic [lbd_pkg::ACC_W-1:0] osc_acc;       // Oscillator phase
	logic [lbd_pkg::ACC_W:0]   osc_sum;
	logic                      int_tick;      // Internal oscillator edge
	logic [2:0]  ext_sync;                    // Pin synchroniser
	logic        ext_level, next_ext_level;   // Agreed pin level
	logic        ext_edge;
	logic [10:0] ext_quiet, next_ext_quiet;   // Cycles since last edge
	logic        ext_ok;
	logic        use_ext;
	logic        pwm_tick;
	logic        next_fwd;
	lbd_pkg::lbd_clk_sel_e clk_sel;

	always_comb begin
		clk_sel = lbd_pkg::lbd_clk_sel_e'(gen_cfg[lbd_pkg::CLK_SEL_LSB +: 2]);
		osc_sum = {1'h0, osc_acc} + {1'h0, lbd_pkg::OSC_INC};
		int_tick = osc_sum[lbd_pkg::ACC_W];
		// A change counts once the last two stages agree
		next_ext_level = (ext_sync[1] == ext_sync[2]) ? ext_sync[2]
			: ext_level;
		ext_edge = next_ext_level & ~ext_level;
		next_ext_quiet = ext_edge ? 11'h000
			: (ext_quiet == 11'(lbd_pkg::EXT_LOSS_CYC)) ? ext_quiet
			: ext_quiet + 11'h001;
		ext_ok = ext_quiet < 11'(lbd_pkg::EXT_LOSS_CYC);
		use_ext = clk_sel[1] & ext_ok;
		pwm_tick = use_ext ? ext_edge : int_tick;
		// Forward the oscillator or pass the input through
		case (clk_sel)
			lbd_pkg::LBD_CLK_INT_OUT: next_fwd = osc_acc[lbd_pkg::ACC_W-1];
			lbd_pkg::LBD_CLK_EXT_OUT: next_fwd = use_ext ? ext_level
				: osc_acc[lbd_pkg::ACC_W-1];
			default: next_fwd = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			osc_acc    <= 24'h000000;
			ext_sync   <= 3'h0;
			ext_level  <= 1'b0;
			// Start as absent so no stray edge is trusted
			ext_quiet  <= 11'(lbd_pkg::EXT_LOSS_CYC);
			timing_forward_output <= 1'b0;
			pump_tick  <= 1'b0;
		end else begin
			osc_acc    <= osc_sum[lbd_pkg::ACC_W-1:0];
			ext_sync   <= {ext_sync[1:0], ext_timing_input};
			ext_level  <= next_ext_level;
			ext_quiet  <= next_ext_quiet;
			timing_forward_output <= next_fwd;
			pump_tick  <= int_tick;
		end
	end

	// ------------------------------------------------------------
	// Dimming timebase
	// ------------------------------------------------------------
	logic [lbd_pkg::CNT_W-1:0] count, next_count;  // Free-running counter
	logic [3:0]  pre, next_pre;                    // Ticks per count
	logic [3:0]  pre_lim;
	logic        cnt_adv;
	logic        cycle_end;

	always_comb begin
		// 2, 4, 8 or 16 ticks per count: 8192..65536 per cycle
		pre_lim = 4'((5'h02 << gen_cfg[lbd_pkg::DIV_LSB +: 2]) - 5'h01);
		cnt_adv = pwm_tick && (pre >= pre_lim);
		cycle_end = cnt_adv && (count == 12'hfff);
		next_pre = pwm_tick ? (cnt_adv ? 4'h0 : pre + 4'h1) : pre;
		next_count = cnt_adv ? count + 12'h001 : count;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			count <= 12'h000;
			pre   <= 4'h0;
		end else begin
			count <= next_count;
			pre   <= next_pre;
		end
	end

	// ------------------------------------------------------------
	// Switch channels
	// ------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : gen_chan
		lbd_pkg::lbd_chan_cfg_s ccfg;
		assign ccfg = '{duty_target: duty_tgt[g], phase_delay: phase[g],
			step_hold_cycles: hold[g], fade: fade_sel[g]};
		lbd_channel u_chan (
			.core_clk    (core_clk),
			.rst         (rst),
			.cfg         (ccfg),
			.count       (count),
			.cnt_adv     (cnt_adv),
			.cycle_end   (cycle_end),
			.go_en       (go_ctrl[lbd_pkg::GO_EN_BIT]),
			.switch_open (switch_open[g]),
			.duty_now    (duty_now[g])
		);
	end

	// ------------------------------------------------------------
	// Spreading, pin codes and thermistor
	// ------------------------------------------------------------
	logic [8:0]  quiet, next_quiet;        // Cycles since last access
	logic        next_spread;
	logic [2:0][14:0] id_sync, bin_sync;   // Level synchronisers
	logic [3:0]  next_id, next_bin;
	logic [31:0] therm_cnt, next_therm_cnt;

	// Count comparator trips of a thermometer code
	function automatic logic [3:0] lbd_level(input logic [14:0] t);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < 15; k++) begin
			n = n + {3'h0, t[k]};
		end
		return n;
	endfunction : lbd_level

	always_comb begin
		next_quiet = (reg_req.wr | reg_req.rd) ? 9'h000
			: (quiet == 9'(lbd_pkg::SPREAD_HOLD_CYC)) ? quiet
			: quiet + 9'h001;
		next_spread = SPREAD_VARIANT
			&& (next_quiet == 9'(lbd_pkg::SPREAD_HOLD_CYC));
		// Codes move only on agreed stages, as slow as the pins are
		next_id  = (id_sync[1] == id_sync[2]) ? lbd_level(id_sync[2])
			: device_id;
		next_bin = (bin_sync[1] == bin_sync[2]) ? lbd_level(bin_sync[2])
			: binning_code;
		next_therm_cnt = (therm_cnt >= 32'(THERM_PERIOD_CYC - 1)) ? 32'h0
			: therm_cnt + 32'h1;
		next_therm_val = (therm_cnt >= 32'(THERM_PERIOD_CYC - 1))
			? thermistor_input : therm_val;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			quiet         <= 9'h000;
			spread_enable <= 1'b0;
			id_sync       <= '0;
			bin_sync      <= '0;
			device_id     <= 4'h0;
			binning_code  <= 4'h0;
			therm_cnt     <= 32'h0;
			therm_val     <= 8'h00;
		end else begin
			quiet         <= next_quiet;
			spread_enable <= next_spread;
			id_sync       <= {id_sync[1:0], id_resistor_pin};
			bin_sync      <= {bin_sync[1:0], binning_resistor_pin};
			device_id     <= next_id;
			binning_code  <= next_bin;
			therm_cnt     <= next_therm_cnt;
			therm_val     <= next_therm_val;
		end
	end

endmodule : lbd_dimmer

// >>> test/lbd_dimmer_chk.sv
/*
 * Port checker for the LED bypass dimmer top.
 * Assumes it is bound onto lbd_dimmer and sees only its ports.
 */
`timescale 1ns/1ps
module lbd_dimmer_chk #(
	parameter int THERM_PERIOD_CYC = 50
) (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst,
	// Register port
	input wire lbd_pkg::lbd_reg_req_s reg_req,
	input wire logic [15:0]           reg_rdata,
	input wire logic                  reg_rvalid,
	// Pins and outputs
	input wire logic                  timing_forward_output,
	input wire logic [14:0]           id_resistor_pin,
	input wire logic [14:0]           binning_resistor_pin,
	input wire logic [11:0]           switch_open,
	input wire logic                  pump_tick,
	input wire logic                  spread_enable,
	input wire logic [3:0]            device_id,
	input wire logic [3:0]            binning_code
);
	// ------------------------------------------------------------
	// Shadow registers
	// ------------------------------------------------------------
	logic go_sh;   // Go enable as last written
	logic sel_out; // Forwarding bit of clock select

	// Track writes so gating can be judged from the ports alone
	always_ff @(posedge core_clk) begin
		if (rst) begin
			go_sh   <= 1'b0;
			sel_out <= 1'b0;
		end else if (reg_req.wr) begin
			if (reg_req.addr == lbd_pkg::OFS_GO_CTRL)
				go_sh <= reg_req.wdata[0];
			if (reg_req.addr == lbd_pkg::OFS_GEN_CFG)
				sel_out <= reg_req.wdata[0];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_reset_dark: assert property (
		$fell(rst) |-> switch_open == '0 && !reg_rvalid)
		else $error("outputs not idle after reset");
	a_go_readback: assert property (
		reg_req.rd && reg_req.addr == lbd_pkg::OFS_GO_CTRL
		|=> reg_rdata == 16'($past(go_sh)))
		else $error("go readback wrong");
	a_go_gates: assert property (
		(!go_sh)[*3] |-> switch_open == '0)
		else $error("switch opened without go");
	a_spread_quiet: assert property (
		(reg_req.wr || reg_req.rd) |=> !spread_enable[*8])
		else $error("spreading during access");
	a_pump_period: assert property (
		pump_tick |=> !pump_tick[*8] ##[1:6] pump_tick)
		else $error("pump tick off internal rate");
	// Slack of eight cycles covers the decode pipeline
	a_id_decode: assert property (
		($stable(id_resistor_pin) && $stable(binning_resistor_pin))[*8]
		|-> device_id == 4'($countones(id_resistor_pin))
		&& binning_code == 4'($countones(binning_resistor_pin)))
		else $error("pin code decode wrong");
	a_read_answer: assert property (
		reg_req.rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_fwd_idle: assert property (
		(!sel_out)[*6] |-> !timing_forward_output)
		else $error("forward output active while off");

	// Main scenarios reached
	c_lit: cover property (switch_open[0]);
	c_read: cover property (reg_req.rd ##1 reg_rvalid);
	c_spread: cover property ($rose(spread_enable));

endmodule : lbd_dimmer_chk

bind lbd_dimmer lbd_dimmer_chk #(.THERM_PERIOD_CYC(THERM_PERIOD_CYC))
	lbd_dimmer_chk_inst (.core_clk(core_clk), .rst(rst),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.timing_forward_output(timing_forward_output),
	.id_resistor_pin(id_resistor_pin),
	.binning_resistor_pin(binning_resistor_pin),
	.switch_open(switch_open), .pump_tick(pump_tick),
	.spread_enable(spread_enable), .device_id(device_id),
	.binning_code(binning_code));

// >>> test/lbd_host_model.sv
/*
 * Host side of the register port: write and read tasks.
 * Assumes callers enter just after a rising edge of core_clk.
 */
`timescale 1ns/1ps
module lbd_host_model (
	// Clock
	input  wire logic                  core_clk,
	// Register port
	output lbd_pkg::lbd_reg_req_s      reg_req,
	input  wire logic [15:0]           reg_rdata,
	input  wire logic                  reg_rvalid
);
	initial reg_req = '0;

	// One write; an idle edge follows so strobes never double up
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_req.addr  <= a;
		reg_req.wdata <= d;
		reg_req.wr    <= 1'b1;
		@(posedge core_clk);
		reg_req.wr    <= 1'b0;
		reg_req.wdata <= ~d; // Stale data never looks valid
		@(posedge core_clk);
	endtask : wr

	// One read; data taken at the edge where the answer is high
	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output logic ok);
		reg_req.addr <= a;
		reg_req.rd   <= 1'b1;
		@(posedge core_clk);
		reg_req.rd   <= 1'b0;
		reg_req.addr <= ~a;
		@(posedge core_clk);
		ok = reg_rvalid;
		d  = reg_rdata;
	endtask : rd

endmodule : lbd_host_model

// >>> test/lbd_dimmer_tb.sv
/*
 * Self-checking bench for lbd_dimmer through its register port.
 * Assumes the external clock toggles every second core edge when enabled.
 */
`timescale 1ns/1ps
module lbd_dimmer_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int TP = 50; // Short thermistor period
	logic                  core_clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  ext_on = 1'b0;
	logic                  ext_timing_input = 1'b0;
	logic                  ext_div = 1'b0;  // Halves the external toggle
	logic [14:0]           id_resistor_pin = 15'h007f;
	logic [14:0]           binning_resistor_pin = 15'h7fff;
	logic [7:0]            thermistor_input = 8'ha5;
	lbd_pkg::lbd_reg_req_s reg_req;
	logic [15:0]           reg_rdata;
	logic                  reg_rvalid;
	logic                  timing_forward_output;
	logic [11:0]           switch_open;
	int                    bad_count = 0;
	int                    comparisons = 0;
	int                    hi;  // Cycles switch 0 lit
	int                    gap; // Cycles from switch 0 to 1 lighting
	int                    e;   // Forwarded rising edges
	logic                  prev;

	always #2.5 core_clk = ~core_clk;
	// External clock: a rising edge every four core cycles, since a pin
	// that toggles every cycle never shows two agreeing samples
	always @(posedge core_clk) begin
		ext_div <= ext_on & ~ext_div;
		if (ext_div)
			ext_timing_input <= ~ext_timing_input;
	end

	lbd_dimmer #(.THERM_PERIOD_CYC(TP), .SPREAD_VARIANT(1'b1))
		lbd_dimmer_inst (.core_clk(core_clk), .rst(rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.ext_timing_input(ext_timing_input),
		.timing_forward_output(timing_forward_output),
		.id_resistor_pin(id_resistor_pin),
		.binning_resistor_pin(binning_resistor_pin),
		.thermistor_input(thermistor_input), .switch_open(switch_open),
		.pump_tick(), .spread_enable(), .device_id(), .binning_code());
	lbd_host_model lbd_host_model_inst (.core_clk(core_clk),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// Missing answer turns into unknown data, which never matches
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		lbd_host_model_inst.rd(a, d, ok);
		check(ok === 1'b1 ? d : 16'hxxxx, exp);
	endtask : rd_chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		lbd_host_model_inst.wr(a, d);
	endtask : wr

	// Lit time of switch 0 and its lead over switch 1, bounded waits
	task automatic run_len;
		int n;
		n = 0;
		while (switch_open[0] !== 1'b1 && n < 40000) begin
			@(posedge core_clk);
			n++;
		end
		hi = 1;
		gap = 0;
		while (switch_open[1] !== 1'b1 && n < 80000) begin
			@(posedge core_clk);
			n++;
			gap++;
			if (switch_open[0] === 1'b1)
				hi++;
		end
	endtask : run_len

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd_chk(lbd_pkg::OFS_GO_CTRL, 16'h0000);
		rd_chk(lbd_pkg::OFS_GEN_CFG, 16'h0000);
		rd_chk(8'h10, 16'h0000);
		check(16'(switch_open), 16'h0000);
		repeat (TP + 10) @(posedge core_clk);
		rd_chk(lbd_pkg::OFS_THERM, 16'h00a5);
		rd_chk(lbd_pkg::OFS_ID_CODE, 16'h00f7);
		repeat (300) @(posedge core_clk);
		check(16'(lbd_dimmer_inst.spread_enable), 16'h0001);
		wr(lbd_pkg::OFS_GO_CTRL, 16'h0000);
		check(16'(lbd_dimmer_inst.spread_enable), 16'h0000);
		// Duties and phases go in before the outputs are released
		wr(lbd_pkg::OFS_DUTY, 16'h000f);
		wr(lbd_pkg::OFS_DUTY + 8'h02, 16'h1fff);
		wr(lbd_pkg::OFS_PHASE, 16'h0100);
		wr(lbd_pkg::OFS_PHASE + 8'h01, 16'h0120);
		// Switch 3 fades: from zero its first step lands on one
		wr(lbd_pkg::OFS_FADE_SEL, 16'h0008);
		wr(lbd_pkg::OFS_DUTY + 8'h03, 16'h0800);
		ext_on <= 1'b1;
		wr(lbd_pkg::OFS_GEN_CFG, 16'h0002);
		wr(lbd_pkg::OFS_GO_CTRL, 16'h0001);
		// First cycle still runs the reset duty of zero: one count lit,
		// eight core cycles per count
		run_len();
		check(16'(hi), 16'h0008);
		check(16'(gap), 16'h0100);
		// Pass the first cycle end, then slow the count before the window
		repeat (31000) @(posedge core_clk);
		wr(lbd_pkg::OFS_GEN_CFG, 16'h0006);
		run_len();
		check(16'(hi), 16'h0100);
		check(16'(gap), 16'h0200);
		rd_chk(lbd_pkg::OFS_DUTY, 16'h000f);
		rd_chk(lbd_pkg::OFS_DUTY + 8'h02, 16'h1000);
		rd_chk(lbd_pkg::OFS_DUTY + 8'h03, 16'h0001);
		// Forwarded clock is present only for odd select codes
		for (int s = 0; s < 4; s++) begin
			wr(lbd_pkg::OFS_GEN_CFG, 16'(s));
			repeat (8) @(posedge core_clk);
			e = 0;
			prev = timing_forward_output;
			repeat (200) begin
				@(posedge core_clk);
				if (timing_forward_output === 1'b1 && prev === 1'b0)
					e++;
				prev = timing_forward_output;
			end
			check(16'(e != 0), {15'h0000, s[0]});
		end
		wr(lbd_pkg::OFS_GO_CTRL, 16'h0000);
		repeat (4) @(posedge core_clk);
		check(16'(switch_open), 16'h0000);
		stop_test();
	end

	// Watchdog: the tests need about 40,000 cycles, one dimming cycle
	// of 32,768 cycles among them
	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end

endmodule : lbd_dimmer_tb
